// *** design/lbwc_top.sv ***
// Wake-up and mode control of a single-wire LIN transceiver
module lbwc_top #(
  parameter lbwc_pkg::lbwc_variant_t VARIANT     = lbwc_pkg::LBWC_WAKE_LOW,
  parameter bit                      FAULT_PINS  = 1'b0,
  parameter int                      ORIG_DB_CYC = lbwc_pkg::ORIG_DEBOUNCE_CYC,
  parameter int                      REV_DB_CYC  = lbwc_pkg::REV_DEBOUNCE_CYC
) (
  input  wire logic                 sys_clk,
  input  wire logic                 reset_n,
  input  wire logic                 bus_line_in,
  input  wire logic                 txd_in,
  input  wire logic                 txe_in,
  input  wire logic                 sleep_req,
  output logic                      regulator_enable_out,
  output logic                      bus_pullup_en,
  output logic                      rx_active,
  output logic                      tx_driver_en,
  output logic                      wake_event,
  output lbwc_pkg::lbwc_mode_t      mode
);
  import lbwc_pkg::*;

  localparam logic [READY_CNT_W-1:0] DWELL_LAST =
    READY_CNT_W'(READY_DWELL_CYC - 1);
  localparam logic [READY_CNT_W-1:0] DWELL_ONE  = READY_CNT_W'(1);
  // Debounce window per variant
  localparam int DB_CYC =
    (VARIANT == LBWC_WAKE_RISE) ? REV_DB_CYC : ORIG_DB_CYC;

  lbwc_wake_if wif ();

  lbwc_mode_t                 state_r;
  lbwc_mode_t                 state_nxt;
  logic [READY_CNT_W-1:0]     dwell_r;
  logic [READY_CNT_W-1:0]     dwell_nxt;
  logic                       reg_en_r;
  logic                       pullup_r;
  logic                       rx_act_r;
  logic                       tx_en_r;
  logic                       wake_evt_r;

  // ***************************************************************
  // Mode decode helpers
  // ***************************************************************
  // Every mode but power-down keeps the regulator and receiver alive
  function automatic logic mode_awake(input lbwc_mode_t m);
    return (m != LBWC_POWER_DOWN);
  endfunction

  // Only Operation may drive the bus or load it with the pull-up
  function automatic logic mode_drives(input lbwc_mode_t m);
    return (m == LBWC_OPERATION);
  endfunction

  // ***************************************************************
  // Wake detection
  // ***************************************************************
  assign wif.bus_rx = bus_line_in;
  // Detector only looks at the bus while powered down
  assign wif.armed  = ~mode_awake(state_r);

  lbwc_wake_det #(
    .VARIANT      (VARIANT),
    .DEBOUNCE_CYC (DB_CYC)
  ) u_wake_det (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .wif     (wif.det)
  );

  // ***************************************************************
  // Hold-low sensing
  // ***************************************************************
  // Fault-reporting variant uses the transmit-enable pin, else TxD.
  // A host that follows the forced power-down sequence keeps this low
  // until it has seen real traffic, so the pull-up stays off.
  wire tx_hold = FAULT_PINS ? ~txe_in : ~txd_in;

  // Ready lingers a fixed time so the host can set its hold input first
  // The dwell count parks at its last value and clears outside Ready
  wire dwell_done = (dwell_r == DWELL_LAST);
  assign dwell_nxt = (state_r != LBWC_READY) ? '0 :
                     dwell_done               ? dwell_r :
                                                dwell_r + DWELL_ONE;

  // ***************************************************************
  // Mode sequencing
  // ***************************************************************
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      LBWC_POWER_DOWN: begin
        if (wif.wake) begin
          state_nxt = LBWC_READY;
        end
      end
      LBWC_READY: begin
        // Sleep outranks the dwell decision
        if (sleep_req) begin
          state_nxt = LBWC_POWER_DOWN;
        end else if (dwell_done && tx_hold) begin
          state_nxt = LBWC_TX_OFF;
        end else if (dwell_done) begin
          state_nxt = LBWC_OPERATION;
        end
      end
      LBWC_TX_OFF: begin
        // The host releases its hold once it has seen real traffic
        if (sleep_req) begin
          state_nxt = LBWC_POWER_DOWN;
        end else if (!tx_hold) begin
          state_nxt = LBWC_OPERATION;
        end
      end
      LBWC_OPERATION: begin
        // No dominant timeout here: a bus stuck low keeps this mode
        if (sleep_req) begin
          state_nxt = LBWC_POWER_DOWN;
        end else if (FAULT_PINS && tx_hold) begin
          // Only the enable pin may stop the driver; TxD low is data
          state_nxt = LBWC_TX_OFF;
        end
      end
      default: begin
        // A corrupt code falls back to the lowest-current mode
        state_nxt = LBWC_POWER_DOWN;
      end
    endcase
  end

  // ***************************************************************
  // Output decode from the next mode
  // ***************************************************************
  // Decoding the next mode lets the outputs change on the same edge as
  // the mode, so the regulator rises one cycle after the wake pulse,
  // far inside either wake-to-enable limit.
  wire nxt_awake  = mode_awake(state_nxt);
  wire nxt_oper   = mode_drives(state_nxt);
  // A wake pulse only counts while the detector is still armed
  wire wake_taken = wif.wake & ~mode_awake(state_r);

  // ***************************************************************
  // Mode and dwell registers
  // ***************************************************************
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= LBWC_POWER_DOWN;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dwell_r <= '0;
    end else begin
      dwell_r <= dwell_nxt;
    end
  end

  // ***************************************************************
  // Registered outputs
  // ***************************************************************
  // Kept as flip-flops so the pins never glitch while the mode moves
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_en_r <= 1'b0;
    end else begin
      reg_en_r <= nxt_awake;
    end
  end

  // Pull-up and driver follow Operation only; Tx-off leaves both off
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pullup_r <= 1'b0;
    end else begin
      pullup_r <= nxt_oper;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_act_r <= 1'b0;
    end else begin
      rx_act_r <= nxt_awake;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_en_r <= 1'b0;
    end else begin
      tx_en_r <= nxt_oper;
    end
  end

  // One-cycle marker of the edge at which a wake was accepted
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wake_evt_r <= 1'b0;
    end else begin
      wake_evt_r <= wake_taken;
    end
  end

  assign regulator_enable_out = reg_en_r;
  assign bus_pullup_en        = pullup_r;
  assign rx_active            = rx_act_r;
  assign tx_driver_en         = tx_en_r;
  assign wake_event           = wake_evt_r;
  assign mode                 = state_r;

endmodule

// *** design/lbwc_wake_det.sv ***
// Bus activity wake detector, one of two detection variants
module lbwc_wake_det
  import lbwc_pkg::*;
#(
  parameter lbwc_variant_t VARIANT      = LBWC_WAKE_LOW,
  parameter int            DEBOUNCE_CYC = ORIG_DEBOUNCE_CYC
) (
  input  wire logic sys_clk,
  input  wire logic reset_n,
  lbwc_wake_if.det  wif
);

  // The count runs one past the debounce time so that the revised
  // variant only qualifies a low strictly longer than that time
  localparam int CW = $clog2(DEBOUNCE_CYC + 2);
  localparam logic [CW-1:0] LIMIT     = CW'(DEBOUNCE_CYC + 1);
  localparam logic [CW-1:0] LIMIT_M1  = CW'(DEBOUNCE_CYC - 1);
  localparam logic [CW-1:0] ONE       = CW'(1);

  logic [CW-1:0] low_cnt_r;
  logic [CW-1:0] low_cnt_nxt;
  logic          wake_r;

  // ***************************************************************
  // Low-time qualification
  // ***************************************************************
  wire bus_low   = wif.armed & ~wif.bus_rx;
  wire qualified = (low_cnt_r == LIMIT);
  // Saturating count keeps a long low from wrapping into a false short one
  assign low_cnt_nxt = ~bus_low  ? '0 :
                       qualified ? low_cnt_r :
                                   low_cnt_r + ONE;

  // Original: pulse the cycle the low becomes long enough
  wire wake_low  = bus_low & (low_cnt_r == LIMIT_M1);
  // Revised: pulse only on the rise that ends a qualified low
  wire wake_rise = wif.armed & wif.bus_rx & qualified;
  wire wake_sel  = (VARIANT == LBWC_WAKE_RISE) ? wake_rise : wake_low;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      low_cnt_r <= '0;
      wake_r    <= 1'b0;
    end else begin
      low_cnt_r <= low_cnt_nxt;
      wake_r    <= wake_sel;
    end
  end

  assign wif.wake = wake_r;

endmodule

// *** dv/lbwc_node_model.sv ***
// Far-side LIN node model that pulls the bus dominant on request
module lbwc_node_model (
  input  wire logic pull_low,
  output logic      bus_line
);
  timeunit 1ns;
  timeprecision 100ps;
  // A released bus is driven straight back to recessive by the model
  assign bus_line = pull_low ? 1'b0 : 1'b1;
endmodule

// *** dv/lbwc_props.sv ***
// Concurrent checks on the wake and mode control ports
module lbwc_props
  import lbwc_pkg::*;
#(
  parameter lbwc_variant_t VARIANT     = LBWC_WAKE_LOW,
  parameter bit            FAULT_PINS  = 1'b0,
  parameter int            ORIG_DB_CYC = ORIG_DEBOUNCE_CYC,
  parameter int            REV_DB_CYC  = REV_DEBOUNCE_CYC
) (
  input wire logic                 sys_clk,
  input wire logic                 reset_n,
  input wire logic                 bus_line_in,
  input wire logic                 txd_in,
  input wire logic                 txe_in,
  input wire logic                 sleep_req,
  input wire logic                 regulator_enable_out,
  input wire logic                 bus_pullup_en,
  input wire logic                 rx_active,
  input wire logic                 tx_driver_en,
  input wire logic                 wake_event,
  input wire lbwc_pkg::lbwc_mode_t mode
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] low_cnt_r;
  logic [15:0] low_cnt_nxt;
  logic        pd;
  logic        hold;
  assign pd = (mode == LBWC_POWER_DOWN);
  assign hold = FAULT_PINS ? txe_in : txd_in;
  assign low_cnt_nxt = (pd && !bus_line_in) ? low_cnt_r + 16'h1 : 16'h0;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) low_cnt_r <= 16'h0;
    else low_cnt_r <= low_cnt_nxt;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  reg_en_mode_a: assert property (regulator_enable_out == !pd)
    else $error("regulator enable disagrees with mode");
  ready_io_a: assert property (mode == LBWC_READY |-> rx_active &&
    !tx_driver_en) else $error("ready mode driver state wrong");
  pullup_oper_a: assert property (bus_pullup_en ==
    (mode == LBWC_OPERATION)) else $error("pull-up not tied to operation");
  orig_wake_a: assert property (VARIANT == LBWC_WAKE_LOW && pd &&
    !bus_line_in && low_cnt_r == ORIG_DB_CYC - 1 && !sleep_req
    |-> ##2 mode == LBWC_READY) else $error("original wake missed");
  rev_wake_a: assert property (VARIANT == LBWC_WAKE_RISE && pd &&
    bus_line_in && low_cnt_r > REV_DB_CYC && !sleep_req
    |-> ##2 mode == LBWC_READY) else $error("revised wake missed");
  wake_cause_a: assert property ($rose(wake_event) |->
    (VARIANT == LBWC_WAKE_LOW ? $past(low_cnt_r, 2) == ORIG_DB_CYC - 1
    : ($past(bus_line_in, 2) && $past(low_cnt_r, 2) > REV_DB_CYC)))
    else $error("wake without qualified bus low");
  wake_ready_a: assert property (wake_event |-> mode == LBWC_READY
    ##1 (mode == LBWC_READY)[*8]) else $error("wake did not hold ready");
  ready_exit_a: assert property ((mode == LBWC_READY ##1 !pd &&
    mode != LBWC_READY) |-> mode == ($past(hold) ? LBWC_OPERATION
    : LBWC_TX_OFF)) else $error("wrong mode after ready");
  sleep_pd_a: assert property (sleep_req |=> pd && !rx_active)
    else $error("sleep request not obeyed");
endmodule
bind lbwc_top lbwc_props #(.VARIANT(VARIANT), .FAULT_PINS(FAULT_PINS),
  .ORIG_DB_CYC(ORIG_DB_CYC), .REV_DB_CYC(REV_DB_CYC)) u_props (
  .sys_clk(sys_clk), .reset_n(reset_n), .bus_line_in(bus_line_in),
  .txd_in(txd_in), .txe_in(txe_in), .sleep_req(sleep_req),
  .regulator_enable_out(regulator_enable_out),
  .bus_pullup_en(bus_pullup_en), .rx_active(rx_active),
  .tx_driver_en(tx_driver_en), .wake_event(wake_event), .mode(mode));

// *** dv/test_lbwc_top.sv ***
// Self-checking bench for both wake detection variants
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; \
  $display("wrong value at %0t got %h exp %h", $time, a, b); end end
module test_lbwc_top;
  import lbwc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk, reset_n, txd, txe, sleep, lo_a, lo_b, bus_a, bus_b;
  logic reg_a, pu_a, rx_a, tx_a, wk_a, reg_b, pu_b, rx_b, tx_b, wk_b;
  lbwc_mode_t mode_a, mode_b;
  int fails, comparisons, cyc;
  lbwc_node_model node_a (.pull_low(lo_a), .bus_line(bus_a));
  lbwc_node_model node_b (.pull_low(lo_b), .bus_line(bus_b));
  lbwc_top #(.VARIANT(LBWC_WAKE_LOW), .ORIG_DB_CYC(8)) dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .bus_line_in(bus_a),
    .txd_in(txd), .txe_in(1'b1), .sleep_req(sleep),
    .regulator_enable_out(reg_a), .bus_pullup_en(pu_a), .rx_active(rx_a),
    .tx_driver_en(tx_a), .wake_event(wk_a), .mode(mode_a));
  lbwc_top #(.VARIANT(LBWC_WAKE_RISE), .FAULT_PINS(1'b1),
    .REV_DB_CYC(20)) dut_rev (
    .sys_clk(sys_clk), .reset_n(reset_n), .bus_line_in(bus_b),
    .txd_in(1'b1), .txe_in(txe), .sleep_req(sleep),
    .regulator_enable_out(reg_b), .bus_pullup_en(pu_b), .rx_active(rx_b),
    .tx_driver_en(tx_b), .wake_event(wk_b), .mode(mode_b));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic end_of_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic test_orig();
    lo_a = 1'b1;
    step(7);
    lo_a = 1'b0;
    step(4);
    `CHK(mode_a, LBWC_POWER_DOWN)
    lo_a = 1'b1;
    step(8);
    lo_a = 1'b0;
    step(1);
    `CHK({wk_a, reg_a, rx_a, tx_a}, 4'he)
    `CHK(mode_a, LBWC_READY)
    step(260);
    `CHK(mode_a, LBWC_TX_OFF)
    txd = 1'b1;
    step(2);
    `CHK({mode_a, pu_a, tx_a}, {LBWC_OPERATION, 2'h3})
    sleep = 1'b1;
    step(1);
    sleep = 1'b0;
    `CHK({mode_a, reg_a}, {LBWC_POWER_DOWN, 1'b0})
    $display("test original wake done");
  endtask
  task automatic test_rev();
    lo_b = 1'b1;
    step(20);
    lo_b = 1'b0;
    step(4);
    `CHK(mode_b, LBWC_POWER_DOWN)
    lo_b = 1'b1;
    step(40);
    `CHK(mode_b, LBWC_POWER_DOWN)
    lo_b = 1'b0;
    step(2);
    `CHK({mode_b, wk_b, reg_b}, {LBWC_READY, 2'h3})
    step(260);
    `CHK({mode_b, pu_b}, {LBWC_OPERATION, 1'b1})
    txe = 1'b0;
    step(2);
    `CHK({mode_b, pu_b, tx_b, rx_b}, {LBWC_TX_OFF, 3'h1})
    txe = 1'b1;
    step(1);
    `CHK({mode_b, tx_b}, {LBWC_OPERATION, 1'b1})
    sleep = 1'b1;
    step(1);
    sleep = 1'b0;
    `CHK({mode_b, reg_b, rx_b}, {LBWC_POWER_DOWN, 2'h0})
    $display("test revised wake done");
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      end_of_test();
    end
  end
  initial begin
    {reset_n, txd, sleep, lo_a, lo_b} = 5'h0;
    txe = 1'b1;
    step(10);
    reset_n = 1'b1;
    step(2);
    test_orig();
    test_rev();
    end_of_test();
  end
endmodule

// *** shared/lbwc_pkg.sv ***
// Shared constants and types for the LIN bus wake control block
package lbwc_pkg;

  // ***************************************************************
  // Clock and timing
  // ***************************************************************
  localparam int CLK_MHZ            = 250;
  // Original variant: wake on a low lasting at least this long
  localparam int ORIG_DEBOUNCE_US   = 20;
  // Revised variant: typical bus debounce time
  localparam int REV_DEBOUNCE_US    = 70;
  // Time spent in Ready before the mode decision is taken
  localparam int READY_DWELL_US     = 1;

  localparam int ORIG_DEBOUNCE_CYC  = ORIG_DEBOUNCE_US * CLK_MHZ;
  localparam int REV_DEBOUNCE_CYC   = REV_DEBOUNCE_US * CLK_MHZ;
  localparam int READY_DWELL_CYC    = READY_DWELL_US * CLK_MHZ;
  localparam int READY_CNT_W        = $clog2(READY_DWELL_CYC + 1);

  // ***************************************************************
  // Types
  // ***************************************************************
  typedef enum logic {
    LBWC_WAKE_LOW  = 1'b0,
    LBWC_WAKE_RISE = 1'b1
  } lbwc_variant_t;

  typedef enum logic [3:0] {
    LBWC_POWER_DOWN = 4'h1,
    LBWC_READY      = 4'h2,
    LBWC_TX_OFF     = 4'h4,
    LBWC_OPERATION  = 4'h8
  } lbwc_mode_t;

endpackage

// *** shared/lbwc_wake_if.sv ***
// Carrier between the mode controller and the wake detector
interface lbwc_wake_if;
  logic bus_rx;
  logic armed;
  logic wake;

  modport det (
    input  bus_rx,
    input  armed,
    output wake
  );

  modport ctl (
    output bus_rx,
    output armed,
    input  wake
  );
endinterface
